// *** logic/scr_pkg.sv ***
// Purpose: constants and types for the serial port configuration and
//          status register bank
// Assumes: 50 MHz clk, serial port in mode 0, 7-bit register address
// Notes:   one source for offsets, field positions and reset values
//
// What this block does
// - bit 7 write starts soft reset, self-clears
// - streaming address ascends if bit 5 set
// - serial output driven only while enable set
// - bit 3 echoes the output drive enable
// - bit 2 echoes the address order bit
// - bit 0 mirrors soft reset, also starts it
// - one-transfer bit set disables streaming
`default_nettype none

package scr_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_CFG_A   = 7'h00;
  localparam logic [6:0] ADDR_CFG_B   = 7'h01;
  localparam logic [6:0] ADDR_CAL3_HI = 7'h3e;
  localparam logic [6:0] ADDR_MCLK    = 7'h3f;
  localparam logic [6:0] ADDR_OFUF    = 7'h40;
  localparam logic [6:0] ADDR_SETTLE  = 7'h41;
  localparam logic [6:0] ADDR_INTERR  = 7'h42;
  localparam logic [6:0] ADDR_SPIERR  = 7'h47;
  localparam logic [6:0] ADDR_AINOR   = 7'h48;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int CFGA_SRST      = 7;
  localparam int CFGA_ASC       = 5;
  localparam int CFGA_SDO       = 4;
  localparam int CFGA_SDO_ECHO  = 3;
  localparam int CFGA_ASC_ECHO  = 2;
  localparam int CFGA_SRST_ECHO = 0;
  localparam int CFGB_ONE       = 7;
  localparam int CFGB_RDBACK    = 5;
  localparam int CFGB_DIGIF     = 1;
  localparam int CFGB_BIT0      = 0;
  localparam int SPIE_CRC       = 3;
  localparam int SPIE_SCLK      = 2;
  localparam int SPIE_WRITE     = 1;
  localparam int SPIE_READ      = 0;
  localparam int CMD_READ       = 7;
  localparam logic [7:0] CFGA_RST = 8'h18;
  localparam logic [7:0] CFGB_RST = 8'h80;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ     = 50;
  localparam int SOFT_RST_NS = 200;
  // least time, rounded up to whole cycles
  localparam int SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int SRST_W       = 4;
  localparam logic [SRST_W-1:0] SRST_LOAD = SRST_W'(SOFT_RST_CYC);
  localparam logic [SRST_W-1:0] SRST_ONE  = 4'h1;
  localparam logic [SRST_W-1:0] SRST_IDLE = 4'h0;
  // last divider count; master clock tally advances once per this many plus one clk cycles
  localparam logic [3:0] MCLK_DIV_LAST = 4'h3;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } scr_state_e;

  typedef struct packed {
    logic       one_transfer_only;
    logic       readback_master;
    logic       dig_if_reset;
    logic       addr_ascend;
    logic       serial_out_drive_enable;
    logic       soft_reset_busy;
  } scr_ctrl_s;

  typedef struct packed {
    logic [3:0] filt_overflow;
    logic [3:0] filt_settled;
    logic [3:0] internal_fault;
    logic [3:0] ain_overrange;
    logic       spi_crc_err;
  } scr_stat_s;

endpackage

`default_nettype wire

// *** logic/scr_pin_sync.sv ***
// Purpose: bring serial port pins into the clk domain, find sclk edges
// Assumes: sclk slower than clk / 6 so every level is seen twice
// Notes:   edges are judged on the second stage only
`default_nettype none

module scr_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // raw pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  // synchronised view
  output logic      sdi_s,
  output logic      cs_act,
  output logic      cs_start,
  output logic      cs_end,
  output logic      sclk_rise,
  output logic      sclk_fall
);

  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [1:0] last_r;

  // -----------------------------------------------------------------
  // two flops per pin, chip select idles high
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 3'h2;
      sync_r <= 3'h2;
    end
    else
    begin
      meta_r <= {sdi, cs_n, sclk};
      sync_r <= meta_r;
    end
  end

  // previous stable level for edge detection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      last_r <= 2'h2;
    else
      last_r <= sync_r[1:0];
  end

  // edges; a low chip select gates clock edges
  assign sdi_s     = sync_r[2];
  assign cs_act    = !sync_r[1];
  assign cs_start  = last_r[1] && !sync_r[1];
  assign cs_end    = !last_r[1] && sync_r[1];
  assign sclk_rise = cs_act && !last_r[0] && sync_r[0];
  assign sclk_fall = cs_act && last_r[0] && !sync_r[0];

endmodule

`default_nettype wire

// *** logic/scr_regs.sv ***
// Purpose: serial port slave with configuration and status registers
// Assumes: mode 0 framing, first byte read flag and 7-bit address
// Notes:   soft reset clears registers, not a frame in flight
`default_nettype none

module scr_regs (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // serial port pins
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  output logic                   sdo,
  output logic                   sdo_oe_n,
  // device side
  input  wire scr_pkg::scr_stat_s stat_i,
  output scr_pkg::scr_ctrl_s     ctrl_o,
  output logic [7:0]             cal3_hi_o
);

  logic                        sdi_s;
  logic                        cs_act;
  logic                        cs_start;
  logic                        cs_end;
  logic                        sclk_rise;
  logic                        sclk_fall;
  scr_pkg::scr_state_e         state_r;
  logic [2:0]                  bitcnt_r;
  logic [6:0]                  rx_r;
  logic [7:0]                  rx_byte;
  logic [7:0]                  tx_r;
  logic                        sdo_r;
  logic                        oe_n_r;
  logic                        rw_r;
  logic [6:0]                  addr_r;
  logic [6:0]                  addr_nxt;
  logic                        byte_done;
  logic                        wr_fire;
  logic                        asc_r;
  logic                        sdo_en_r;
  logic [7:0]                  cfgb_r;
  logic [7:0]                  cal3_r;
  logic [scr_pkg::SRST_W-1:0]  srst_cnt_r;
  logic                        srst_busy;
  logic                        srst_done;
  logic [3:0]                  div_r;
  logic [7:0]                  mclk_r;
  scr_pkg::scr_stat_s          stat_r;
  logic [3:0]                  spierr_r;
  logic [3:0]                  spierr_set;
  logic [8:0]                  rd_cmd;
  logic [8:0]                  rd_nxt;

  scr_pin_sync u_sync (
    .clk       (clk),
    .nrst      (nrst),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .sdi_s     (sdi_s),
    .cs_act    (cs_act),
    .cs_start  (cs_start),
    .cs_end    (cs_end),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall)
  );

  // -----------------------------------------------------------------
  // register decode
  // -----------------------------------------------------------------
  // read view: bit 8 says the address is mapped
  function automatic logic [8:0] rd_word(input logic [6:0] a);
    logic [7:0] v;
    logic       hit;
    v   = 8'h00;
    hit = 1'b1;
    unique case (a)
      scr_pkg::ADDR_CFG_A:
      begin
        v[scr_pkg::CFGA_SRST]      = srst_busy;
        v[scr_pkg::CFGA_ASC]       = asc_r;
        v[scr_pkg::CFGA_SDO]       = sdo_en_r;
        v[scr_pkg::CFGA_SDO_ECHO]  = sdo_en_r;
        v[scr_pkg::CFGA_ASC_ECHO]  = asc_r;
        v[scr_pkg::CFGA_SRST_ECHO] = srst_busy;
      end
      scr_pkg::ADDR_CFG_B:   v = cfgb_r;
      scr_pkg::ADDR_CAL3_HI: v = cal3_r;
      scr_pkg::ADDR_MCLK:    v = mclk_r;
      scr_pkg::ADDR_OFUF:    v = {4'h0, stat_r.filt_overflow};
      scr_pkg::ADDR_SETTLE:  v = {4'h0, stat_r.filt_settled};
      scr_pkg::ADDR_INTERR:  v = {4'h0, stat_r.internal_fault};
      scr_pkg::ADDR_SPIERR:  v = {4'h0, spierr_r};
      scr_pkg::ADDR_AINOR:   v = {4'h0, stat_r.ain_overrange};
      default:               hit = 1'b0;
    endcase
    return {hit, v};
  endfunction

  // only these addresses take writes
  function automatic logic wr_ok(input logic [6:0] a);
    return (a == scr_pkg::ADDR_CFG_A) || (a == scr_pkg::ADDR_CFG_B) ||
           (a == scr_pkg::ADDR_CAL3_HI);
  endfunction

  assign rx_byte   = {rx_r, sdi_s};
  assign byte_done = sclk_rise && (bitcnt_r == 3'h7);
  assign wr_fire   = byte_done && (state_r == scr_pkg::ST_DATA) && !rw_r;
  // streaming step follows the order bit
  assign addr_nxt  = asc_r ? 7'(addr_r + 7'h01)
                           : 7'(addr_r - 7'h01);
  assign srst_busy = (srst_cnt_r != scr_pkg::SRST_IDLE);
  assign srst_done = (srst_cnt_r == scr_pkg::SRST_ONE);

  // read words for the command address and the next streaming address;
  // a function result cannot be part-selected, so the words get names
  always_comb
  begin
    rd_cmd = rd_word(rx_byte[6:0]);
    rd_nxt = rd_word(addr_nxt);
  end

  // -----------------------------------------------------------------
  // frame engine: sample on sclk rise, shift out on sclk fall
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r  <= scr_pkg::ST_IDLE;
      bitcnt_r <= 3'h0;
      rx_r     <= 7'h00;
      tx_r     <= 8'h00;
      sdo_r    <= 1'b0;
      rw_r     <= 1'b0;
      addr_r   <= 7'h00;
    end
    else if (cs_start)
    begin
      state_r  <= scr_pkg::ST_CMD;
      bitcnt_r <= 3'h0;
      tx_r     <= 8'h00;
      sdo_r    <= 1'b0;
    end
    else if (!cs_act)
      state_r <= scr_pkg::ST_IDLE;
    else if (sclk_rise)
    begin
      bitcnt_r <= 3'(bitcnt_r + 3'h1);
      rx_r     <= rx_byte[6:0];
      if (byte_done)
      begin
        unique case (state_r)
          scr_pkg::ST_CMD:
          begin
            rw_r    <= rx_byte[scr_pkg::CMD_READ];
            addr_r  <= rx_byte[6:0];
            state_r <= scr_pkg::ST_DATA;
            tx_r    <= rx_byte[scr_pkg::CMD_READ] ?
                       rd_cmd[7:0] : 8'h00;
          end
          scr_pkg::ST_DATA:
            if (cfgb_r[scr_pkg::CFGB_ONE])
            begin
              state_r <= scr_pkg::ST_DONE;
              tx_r    <= 8'h00;
            end
            else
            begin
              addr_r <= addr_nxt;
              tx_r   <= rw_r ? rd_nxt[7:0] : 8'h00;
            end
          scr_pkg::ST_DONE: tx_r <= 8'h00;
          scr_pkg::ST_IDLE: tx_r <= 8'h00;
        endcase
      end
    end
    else if (sclk_fall)
    begin
      sdo_r <= tx_r[7];
      tx_r  <= {tx_r[6:0], 1'b0};
    end
  end

  // output driver stays off unless enabled and selected
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      oe_n_r <= 1'b1;
    else
      oe_n_r <= !(cs_act && sdo_en_r);
  end

  assign sdo      = sdo_r;
  assign sdo_oe_n = oe_n_r;

  // -----------------------------------------------------------------
  // soft reset sequencer; a write while busy does not restart it
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      srst_cnt_r <= scr_pkg::SRST_IDLE;
    else if (srst_busy)
      srst_cnt_r <= scr_pkg::SRST_W'(srst_cnt_r - scr_pkg::SRST_ONE);
    else if (wr_fire && addr_r == scr_pkg::ADDR_CFG_A &&
             (rx_byte[scr_pkg::CFGA_SRST] ||
              rx_byte[scr_pkg::CFGA_SRST_ECHO]))
      srst_cnt_r <= scr_pkg::SRST_LOAD;
  end

  // -----------------------------------------------------------------
  // writable registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      asc_r    <= scr_pkg::CFGA_RST[scr_pkg::CFGA_ASC];
      sdo_en_r <= scr_pkg::CFGA_RST[scr_pkg::CFGA_SDO];
      cfgb_r   <= scr_pkg::CFGB_RST;
      cal3_r   <= scr_pkg::ZERO_RST;
    end
    else if (srst_done)
    begin
      // end of soft reset puts every register back to its default
      asc_r    <= scr_pkg::CFGA_RST[scr_pkg::CFGA_ASC];
      sdo_en_r <= scr_pkg::CFGA_RST[scr_pkg::CFGA_SDO];
      cfgb_r   <= scr_pkg::CFGB_RST;
      cal3_r   <= scr_pkg::ZERO_RST;
    end
    else if (wr_fire)
    begin
      unique case (addr_r)
        scr_pkg::ADDR_CFG_A:
        begin
          asc_r    <= rx_byte[scr_pkg::CFGA_ASC];
          sdo_en_r <= rx_byte[scr_pkg::CFGA_SDO];
        end
        scr_pkg::ADDR_CFG_B:
        begin
          cfgb_r[scr_pkg::CFGB_ONE]    <= rx_byte[scr_pkg::CFGB_ONE];
          cfgb_r[scr_pkg::CFGB_RDBACK] <= rx_byte[scr_pkg::CFGB_RDBACK];
          cfgb_r[scr_pkg::CFGB_DIGIF]  <= rx_byte[scr_pkg::CFGB_DIGIF];
          cfgb_r[scr_pkg::CFGB_BIT0]   <= rx_byte[scr_pkg::CFGB_BIT0];
        end
        scr_pkg::ADDR_CAL3_HI: cal3_r <= rx_byte;
        default: cal3_r <= cal3_r;      // read-only or unmapped
      endcase
    end
  end

  // -----------------------------------------------------------------
  // status: live flags are sampled, port faults are sticky
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stat_r <= '0;
    else if (srst_done)
      stat_r <= '0;
    else
      stat_r <= stat_i;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      spierr_r <= 4'h0;
    else if (srst_done)
      spierr_r <= spierr_set;
    else
      spierr_r <= spierr_r | spierr_set;
  end

  // fault events of this cycle; one that meets the end of a soft reset
  // still lands, so the clear never swallows a fresh fault
  always_comb
  begin
    spierr_set                      = 4'h0;
    spierr_set[scr_pkg::SPIE_CRC]   = stat_r.spi_crc_err;
    spierr_set[scr_pkg::SPIE_SCLK]  = cs_end && bitcnt_r != 3'h0 &&
                                      state_r != scr_pkg::ST_IDLE;
    spierr_set[scr_pkg::SPIE_WRITE] = wr_fire && !wr_ok(addr_r);
    spierr_set[scr_pkg::SPIE_READ]  = byte_done && !rd_cmd[8] &&
                                      state_r == scr_pkg::ST_CMD &&
                                      rx_byte[scr_pkg::CMD_READ];
  end

  // master clock tally on a divided enable, wraps at 8 bits
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r  <= 4'h0;
      mclk_r <= scr_pkg::ZERO_RST;
    end
    else if (srst_done)
    begin
      div_r  <= 4'h0;
      mclk_r <= scr_pkg::ZERO_RST;
    end
    else if (div_r == scr_pkg::MCLK_DIV_LAST)
    begin
      div_r  <= 4'h0;
      mclk_r <= 8'(mclk_r + 8'h01);
    end
    else
      div_r <= 4'(div_r + 4'h1);
  end

  // device-side view
  assign ctrl_o = '{one_transfer_only:       cfgb_r[scr_pkg::CFGB_ONE],
                    readback_master:         cfgb_r[scr_pkg::CFGB_RDBACK],
                    dig_if_reset:            cfgb_r[scr_pkg::CFGB_DIGIF],
                    addr_ascend:             asc_r,
                    serial_out_drive_enable: sdo_en_r,
                    soft_reset_busy:         srst_busy};
  assign cal3_hi_o = cal3_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  localparam int SRST_MAX = scr_pkg::SOFT_RST_CYC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_srst_self_clear: assert property (
    $rose(srst_busy) |-> ##[1:SRST_MAX] !srst_busy)
    else $error("soft reset bit did not clear");
  chk_srst_defaults: assert property (
    $fell(srst_busy) |-> sdo_en_r && !asc_r && cal3_r == 8'h00 &&
                         cfgb_r == scr_pkg::CFGB_RST)
    else $error("soft reset left registers changed");
  chk_srst_bit0: assert property (
    wr_fire && addr_r == scr_pkg::ADDR_CFG_A && !srst_busy &&
    rx_byte[scr_pkg::CFGA_SRST_ECHO]
    |=> srst_busy)
    else $error("bit 0 write did not start soft reset");
  chk_sdo_tristate: assert property (
    !sdo_en_r || !cs_act |=> sdo_oe_n)
    else $error("serial output driven while disabled");
  chk_mirror_drive: assert property (
    byte_done && state_r == scr_pkg::ST_CMD && rx_byte == 8'h80
    |=> tx_r[scr_pkg::CFGA_SDO_ECHO] == $past(sdo_en_r))
    else $error("drive echo bit wrong");
  chk_mirror_order: assert property (
    byte_done && state_r == scr_pkg::ST_CMD && rx_byte == 8'h80
    |=> tx_r[scr_pkg::CFGA_ASC_ECHO] == $past(asc_r) &&
        tx_r[scr_pkg::CFGA_ASC] == $past(asc_r))
    else $error("order echo bit wrong");
  chk_addr_step: assert property (
    byte_done && state_r == scr_pkg::ST_DATA &&
    !cfgb_r[scr_pkg::CFGB_ONE] && !cs_start
    |=> addr_r == ($past(asc_r) ? 7'($past(addr_r) + 7'h01)
                                : 7'($past(addr_r) - 7'h01)))
    else $error("streaming address step wrong");
  chk_single_xfer: assert property (
    byte_done && state_r == scr_pkg::ST_DATA &&
    cfgb_r[scr_pkg::CFGB_ONE] && !cs_start
    |=> state_r == scr_pkg::ST_DONE ##1 $stable(addr_r))
    else $error("streaming not stopped in one-transfer mode");
  chk_fault_sticky: assert property (
    spierr_r != 4'h0 && !srst_done |=> spierr_r != 4'h0)
    else $error("port fault flag lost");

  cov_soft_reset:  cover property ($fell(srst_busy));
  cov_stream_down: cover property (byte_done && state_r == scr_pkg::ST_DATA
                                   && !cfgb_r[scr_pkg::CFGB_ONE] && !asc_r);
  cov_read_cfg_a:  cover property (byte_done && state_r == scr_pkg::ST_CMD
                                   && rx_byte == 8'h80);
  cov_write_err:   cover property ($rose(spierr_r[scr_pkg::SPIE_WRITE]));

endmodule

`default_nettype wire

// *** dv/scr_host.sv ***
// Purpose: serial port host that frames reads and writes for the bench
// Assumes: mode 0, sclk half period of 5 clk, inputs move at clk fall
// Notes:   sdi shows the inverse of its last bit between frames
`default_nettype none

module scr_host (
  // clock
  input  wire logic clk,
  // serial port pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // pins idle: clock low, select high
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  // ------------------------------------------------------------------
  // one frame of nbit bits, MSB first; rx gets each whole byte seen
  // ------------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx[$], input int nbit,
                      output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    b  = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    // synchroniser needs 3 clk before the first edge
    repeat (3) @(negedge clk);
    for (int i = 0; i < nbit; i++)
    begin
      sdi = tx[i / 8][7 - i % 8];
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      b = {b[6:0], sdo_line};
      if (i % 8 == 7)
        rx.push_back(b);
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge clk);
    cs_n = 1'b1;
    // released line must not keep looking valid
    sdi  = ~sdi;
    repeat (4) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// *** dv/test_scr_regs.sv ***
// Purpose: self-checking bench for the serial port register bank
// Assumes: 50 MHz clk, host model frames every access
// Notes:   flag inputs are random but held still while they are read
`default_nettype none

module test_scr_regs;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk;
  logic               nrst;
  logic               sclk;
  logic               cs_n;
  logic               sdi;
  logic               sdo;
  logic               sdo_oe_n;
  wire logic          sdo_line;
  scr_pkg::scr_stat_s stat;
  scr_pkg::scr_ctrl_s ctrl;
  logic [7:0]         cal3;
  logic [7:0]         rx[$];
  logic [7:0]         v;
  logic [6:0]         ra[8] = '{7'h00, 7'h01, 7'h3e, 7'h40, 7'h41,
                                7'h42, 7'h47, 7'h48};
  logic [7:0]         rv[8] = '{8'h18, 8'h80, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00};
  logic [7:0]         srv[2] = '{8'h80, 8'h01};
  int                 err_total;
  int                 n_tests;
  int                 cyc;
  int                 oe_low;
  int                 k;

  // sdo floats whenever the device lets go of it
  assign sdo_line = sdo_oe_n ? 1'bz : sdo;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  scr_regs u_scr_regs (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .stat_i(stat),
    .ctrl_o(ctrl), .cal3_hi_o(cal3));

  scr_host u_scr_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo_line(sdo_line));

  // ------------------------------------------------------------------
  // watchers: drive cycles inside frames, and the hang limit
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!cs_n && sdo_oe_n === 1'b0)
      oe_low <= oe_low + 1;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q[$];
    q = {};
    q.push_back({1'b0, a});
    q.push_back(d);
    u_scr_host.xfer(q, 16, rx);
  endtask

  // rx[0] is sampled during the command byte, data starts at rx[1]
  task automatic rd(input logic [6:0] a, input int n);
    logic [7:0] q[$];
    q = {};
    q.push_back({1'b1, a});
    repeat (n) q.push_back(8'h00);
    u_scr_host.xfer(q, 8 * (n + 1), rx);
  endtask

  function automatic logic [7:0] exp_cfga(input logic asc, input logic drv);
    return {2'b00, asc, drv, drv, asc, 2'b00};
  endfunction

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    stat = '0;
    err_total = 0;
    n_tests = 0;
    v = 8'($urandom(70655));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check(ctrl, 6'h22);
    check(cal3, 8'h00);
    // reset value of every readable register except the clock tally at 0x3f
    foreach (ra[i])
    begin
      rd(ra[i], 1);
      check(rx[1], rv[i]);
    end
    check(oe_low != 0, 1'b1);
    // calibration byte with random data
    repeat (4)
    begin
      v = 8'($urandom);
      wr(7'h3e, v);
      check(cal3, v);
      rd(7'h3e, 1);
      check(rx[1], v);
    end
    // live flags; a write to them is refused and logged
    stat = scr_pkg::scr_stat_s'(17'($urandom));
    stat.spi_crc_err = 1'b0;
    wr(7'h40, 8'hff);
    rd(7'h40, 1);
    check(rx[1], {4'h0, stat.filt_overflow});
    rd(7'h41, 1);
    check(rx[1], {4'h0, stat.filt_settled});
    rd(7'h42, 1);
    check(rx[1], {4'h0, stat.internal_fault});
    rd(7'h48, 1);
    check(rx[1], {4'h0, stat.ain_overrange});
    rd(7'h47, 1);
    check(rx[1], 8'h02);
    // unmapped read, cut frame, checksum fault: all sticky
    rd(7'h10, 1);
    check(rx[1], 8'h00);
    u_scr_host.xfer({8'h3e, 8'haa}, 12, rx);
    check(cal3, v);
    stat.spi_crc_err = 1'b1;
    repeat (3) @(negedge clk);
    stat.spi_crc_err = 1'b0;
    rd(7'h47, 1);
    check(rx[1], 8'h0f);
    // one-transfer mode drops the second byte
    rd(7'h01, 2);
    check(rx[1], 8'h80);
    check(rx[2], 8'h00);
    // reserved bits 6 and 4..2 drop, kept bits 7, 5 and 1 show on the control side
    wr(7'h01, 8'h7f);
    check(ctrl.one_transfer_only, 1'b0);
    check(ctrl, 6'h1a);
    rd(7'h01, 2);
    check(rx[1], 8'h23);
    check(rx[2], exp_cfga(1'b0, 1'b1));
    wr(7'h00, 8'h30);
    check(ctrl.addr_ascend, 1'b1);
    rd(7'h00, 2);
    check(rx[1], exp_cfga(1'b1, 1'b1));
    // ascending lands on 0x01; descending would hit an empty slot
    check(rx[2], 8'h23);
    // tally: samples four equal frames of 171 clk apart, 4 clk a step
    rd(7'h3f, 1);
    v = rx[1];
    repeat (4) rd(7'h3f, 1);
    check(8'(rx[1] - v), 8'hab);
    // drive off: no drive cycles while selected
    wr(7'h00, 8'h20);
    k = oe_low;
    rd(7'h00, 1);
    check(oe_low - k, 0);
    check(ctrl.serial_out_drive_enable, 1'b0);
    // soft reset from bit 7, then from bit 0
    foreach (srv[i])
    begin
      wr(7'h3e, 8'h5a);
      fork
        wr(7'h00, srv[i]);
        begin
          k = 0;
          while (ctrl.soft_reset_busy !== 1'b1 && k < 400)
          begin
            @(negedge clk);
            k++;
          end
          k = 0;
          while (ctrl.soft_reset_busy === 1'b1 && k < 40)
          begin
            @(negedge clk);
            k++;
          end
        end
      join
      check(k, scr_pkg::SOFT_RST_CYC);
      rd(7'h00, 1);
      check(rx[1], 8'h18);
      check(cal3, 8'h00);
      check(ctrl, 6'h22);
    end
    rd(7'h47, 1);
    check(rx[1], 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
